// *** rail_load_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Rail loads and output pins; passive, they only follow their enables
module rail_load_model (
  input wire logic [7:0] enables,
  output logic [7:0] powered
);
  // No soft-start, so a rail counts as up once enabled
  assign powered = enables;
endmodule : rail_load_model
`default_nettype wire

// *** rail_slot_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module rail_slot_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic freshness_seal_flag,
  input wire logic power_up_req,
  input wire logic buck_boost_rail,
  input wire logic third_buck_rail,
  input wire logic low_volt_load_switch,
  input wire logic linear_reg_rail,
  input wire logic gp_output_one,
  input wire logic gp_output_three,
  input wire logic backup_core_rail,
  input wire logic backup_io_rail,
  input wire logic [3:0] strobe_now,
  input wire logic seq_busy
);
  logic [7:0] rails;
  logic moved;
  assign rails = {buck_boost_rail, third_buck_rail, low_volt_load_switch, linear_reg_rail,
    gp_output_one, gp_output_three, backup_core_rail, backup_io_rail};
  // Strobe stepped or power-down began a cycle ago; down starts on ten without a step
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      moved <= 1'b0;
    else
      moved <= $changed(strobe_now) || $rose(seq_busy);
  end
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  a_strobe_in_range:
    assert property (strobe_now <= 4'ha) else $error("strobe beyond ten");
  a_up_first_strobe:
    assert property (!seq_busy && strobe_now == 4'h0 && power_up_req |=>
      seq_busy && strobe_now == ($past(freshness_seal_flag) ? 4'h3 : 4'h1)) else $error("bad first strobe");
  a_seal_skips_low:
    assert property ($changed(strobe_now) && freshness_seal_flag && seq_busy |-> strobe_now >= 4'h3)
      else $error("low strobe with seal broken");
  a_strobe_single_step:
    assert property ($changed(strobe_now) && seq_busy && $past(seq_busy) |->
      strobe_now == $past(strobe_now) + 4'h1 || strobe_now == $past(strobe_now) - 4'h1)
      else $error("strobe skipped a step");
  // Five holds match the short gap of six used by the bench
  a_gap_not_short:
    assert property ($changed(strobe_now) && seq_busy |=> (!seq_busy || $stable(strobe_now)) [*5])
      else $error("gap too short");
  a_gap_bounded:
    assert property ($changed(strobe_now) && seq_busy |-> ##[1:1000] ($changed(strobe_now) || !seq_busy))
      else $error("sequencer stalled");
  a_rail_after_strobe:
    assert property ($changed(rails) |-> moved) else $error("rail moved off strobe");
  a_backup_kept_on:
    assert property (freshness_seal_flag && $past(freshness_seal_flag) |->
      !$fell(backup_core_rail) && !$fell(backup_io_rail)) else $error("backup rail dropped");
endmodule : rail_slot_checker
bind rail_strobe_slot_assign rail_slot_checker u_chk (
  .clk(clk), .rst(rst), .freshness_seal_flag(freshness_seal_flag), .power_up_req(power_up_req),
  .buck_boost_rail(buck_boost_rail), .third_buck_rail(third_buck_rail),
  .low_volt_load_switch(low_volt_load_switch), .linear_reg_rail(linear_reg_rail),
  .gp_output_one(gp_output_one), .gp_output_three(gp_output_three),
  .backup_core_rail(backup_core_rail), .backup_io_rail(backup_io_rail),
  .strobe_now(strobe_now), .seq_busy(seq_busy));
`default_nettype wire

// *** rail_slot_defs.svh ***
`ifndef RAIL_SLOT_DEFS_SVH
`define RAIL_SLOT_DEFS_SVH

// Register offsets
`define SLOT_ASSIGN_BUCKBOOST_BUCK3_ADDR 8'h23
`define SLOT_ASSIGN_BACKUP_ADDR 8'h24
`define SLOT_ASSIGN_SWITCH_LINEAR_ADDR 8'h25
`define SLOT_ASSIGN_GP_OUTPUTS_ADDR 8'h26

// Reset values and backup write mask
`define SLOT_ASSIGN_BUCKBOOST_BUCK3_RST 8'h84
`define SLOT_ASSIGN_BACKUP_RST 8'h10
`define SLOT_ASSIGN_SWITCH_LINEAR_RST 8'h88
`define SLOT_ASSIGN_GP_OUTPUTS_RST 8'h08
`define SLOT_ASSIGN_BACKUP_MASK 8'h33

// Field positions (low bit of each field)
`define HI_FIELD_LSB 4
`define LO_FIELD_LSB 0

// Strobe numbering
`define FIRST_STROBE 4'h1
`define FIRST_MAIN_STROBE 4'h3
`define LAST_STROBE 4'ha

// Timing
`define CLK_HZ 20000000
`define GAP_SHORT_MS 2
`define GAP_LONG_MS 5
`define POWERDOWN_FACTOR 10
`define GAP_SHORT_CYCLES (`GAP_SHORT_MS * `CLK_HZ / 1000)
`define GAP_LONG_CYCLES (`GAP_LONG_MS * `CLK_HZ / 1000)

`endif

// *** rail_slot_pkg.sv ***
`default_nettype none
package rail_slot_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    S_OFF = 4'h1,
    S_STROBE = 4'h2,
    S_WAIT = 4'h4,
    S_ON = 4'h8
  } seq_state_t;

  typedef logic [3:0] slot_code_t;

endpackage : rail_slot_pkg
`default_nettype wire

// *** rail_strobe_slot_assign.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rail_slot_defs.svh"

module rail_strobe_slot_assign
  import rail_slot_pkg::*;
#(
  parameter int GAP_SHORT = `GAP_SHORT_CYCLES,
  parameter int GAP_LONG = `GAP_LONG_CYCLES,
  parameter int DOWN_FACTOR = `POWERDOWN_FACTOR
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic unlock,
  output logic [7:0] reg_rdata,
  input wire logic freshness_seal_flag,
  input wire logic [8:0] gap_delay_select,
  input wire logic powerdown_delay_factor,
  input wire logic power_up_req,
  input wire logic power_down_req,
  output logic buck_boost_rail,
  output logic third_buck_rail,
  output logic low_volt_load_switch,
  output logic linear_reg_rail,
  output logic gp_output_one,
  output logic gp_output_three,
  output logic backup_core_rail,
  output logic backup_io_rail,
  output logic [3:0] strobe_now,
  output logic seq_busy
);

  // Register file state
  logic [7:0] slot_assign_buckboost_buck3;
  logic [7:0] slot_assign_backup;
  logic [7:0] slot_assign_switch_linear;
  logic [7:0] slot_assign_gp_outputs;
  logic unlocked;
  logic [7:0] next_buckboost_buck3;
  logic [7:0] next_backup;
  logic [7:0] next_switch_linear;
  logic [7:0] next_gp_outputs;
  logic next_unlocked;
  logic [7:0] next_rdata;

  // Sequencer state
  seq_state_t state;
  seq_state_t next_state;
  logic dir_down;
  logic next_dir_down;
  logic [3:0] next_strobe;
  logic [19:0] gap_cnt;
  logic [19:0] next_gap_cnt;
  logic [7:0] rails;
  logic [7:0] next_rails;
  logic next_busy;

  // Slot fields and per-rail strobe hits
  slot_code_t slot4 [6];
  logic [1:0] slot2 [2];
  logic [7:0] hit;
  logic [3:0] gap_idx;
  logic [19:0] gap_load;
  logic [3:0] stop_strobe;

  assign slot4[0] = slot_assign_buckboost_buck3[`HI_FIELD_LSB +: 4];
  assign slot4[1] = slot_assign_buckboost_buck3[`LO_FIELD_LSB +: 4];
  assign slot4[2] = slot_assign_switch_linear[`HI_FIELD_LSB +: 4];
  assign slot4[3] = slot_assign_switch_linear[`LO_FIELD_LSB +: 4];
  assign slot4[4] = slot_assign_gp_outputs[`LO_FIELD_LSB +: 4];
  assign slot4[5] = slot_assign_gp_outputs[`HI_FIELD_LSB +: 4];
  assign slot2[0] = slot_assign_backup[`LO_FIELD_LSB +: 2];
  assign slot2[1] = slot_assign_backup[`HI_FIELD_LSB +: 2];

  // Main rails answer only to codes 3h..Ah; anything else never hits
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_main_hit
      assign hit[gi] = (slot4[gi] == strobe_now) && (slot4[gi] >= `FIRST_MAIN_STROBE) &&
                       (slot4[gi] <= `LAST_STROBE);
    end
    for (gi = 0; gi < 2; gi++) begin : g_backup_hit
      assign hit[6 + gi] = ((slot2[gi] == 2'h1) || (slot2[gi] == 2'h2)) &&
                           ({2'h0, slot2[gi]} == strobe_now);
    end
  endgenerate

  // Strobes 1 and 2 are skipped whenever the seal is set
  assign stop_strobe = freshness_seal_flag ? `FIRST_MAIN_STROBE : `FIRST_STROBE;

  // Gap after this strobe: up uses its own select bit, down the one below
  assign gap_idx = dir_down ? strobe_now - 4'h2 : strobe_now - 4'h1;

  // Counter preload; two cycles go to the strobe and step states
  always_comb begin
    logic [19:0] base;
    base = gap_delay_select[gap_idx] ? 20'(GAP_LONG) : 20'(GAP_SHORT);
    if (dir_down && powerdown_delay_factor) begin
      base = 20'(GAP_LONG * DOWN_FACTOR);
      if (!gap_delay_select[gap_idx]) begin
        base = 20'(GAP_SHORT * DOWN_FACTOR);
      end
    end
    gap_load = base - 20'h2;
  end

  // Register writes and reads; the unlock step arms exactly one write
  always_comb begin
    next_buckboost_buck3 = slot_assign_buckboost_buck3;
    next_backup = slot_assign_backup;
    next_switch_linear = slot_assign_switch_linear;
    next_gp_outputs = slot_assign_gp_outputs;
    next_unlocked = unlocked;
    next_rdata = reg_rdata;
    if (unlock) begin
      next_unlocked = 1'b1;
    end
    if (reg_wr) begin
      next_unlocked = 1'b0;
      case (reg_addr)
        `SLOT_ASSIGN_BUCKBOOST_BUCK3_ADDR: begin
          next_buckboost_buck3 = reg_wdata;
        end
        `SLOT_ASSIGN_BACKUP_ADDR: begin
          if (unlocked) begin
            next_backup = reg_wdata & `SLOT_ASSIGN_BACKUP_MASK;
          end
        end
        `SLOT_ASSIGN_SWITCH_LINEAR_ADDR: begin
          if (unlocked) begin
            next_switch_linear = reg_wdata;
          end
        end
        `SLOT_ASSIGN_GP_OUTPUTS_ADDR: begin
          if (unlocked) begin
            next_gp_outputs = reg_wdata;
          end
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `SLOT_ASSIGN_BUCKBOOST_BUCK3_ADDR: next_rdata = slot_assign_buckboost_buck3;
        `SLOT_ASSIGN_BACKUP_ADDR: next_rdata = slot_assign_backup;
        `SLOT_ASSIGN_SWITCH_LINEAR_ADDR: next_rdata = slot_assign_switch_linear;
        `SLOT_ASSIGN_GP_OUTPUTS_ADDR: next_rdata = slot_assign_gp_outputs;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_assign_buckboost_buck3 <= `SLOT_ASSIGN_BUCKBOOST_BUCK3_RST;
      slot_assign_backup <= `SLOT_ASSIGN_BACKUP_RST;
      slot_assign_switch_linear <= `SLOT_ASSIGN_SWITCH_LINEAR_RST;
      slot_assign_gp_outputs <= `SLOT_ASSIGN_GP_OUTPUTS_RST;
      unlocked <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      slot_assign_buckboost_buck3 <= next_buckboost_buck3;
      slot_assign_backup <= next_backup;
      slot_assign_switch_linear <= next_switch_linear;
      slot_assign_gp_outputs <= next_gp_outputs;
      unlocked <= next_unlocked;
      reg_rdata <= next_rdata;
    end
  end

  // Sequencer: one strobe state per strobe, then a counted gap
  always_comb begin
    next_state = state;
    next_dir_down = dir_down;
    next_strobe = strobe_now;
    next_gap_cnt = gap_cnt;
    next_rails = rails;
    next_busy = seq_busy;
    case (state)
      S_OFF: begin
        if (power_up_req) begin
          next_state = S_STROBE;
          next_dir_down = 1'b0;
          next_strobe = stop_strobe;
          next_busy = 1'b1;
        end
      end
      S_STROBE: begin
        if (dir_down) begin
          // Rails outside sequencer control keep their level
          next_rails = rails & ~hit;
          if (freshness_seal_flag) begin
            next_rails[7:6] = rails[7:6];
          end
          if (strobe_now <= stop_strobe) begin
            next_state = S_OFF;
            next_busy = 1'b0;
            next_strobe = 4'h0;
          end else begin
            next_state = S_WAIT;
            next_gap_cnt = gap_load;
          end
        end else begin
          next_rails = rails | hit;
          if (strobe_now == `LAST_STROBE) begin
            next_state = S_ON;
            next_busy = 1'b0;
          end else begin
            next_state = S_WAIT;
            next_gap_cnt = gap_load;
          end
        end
      end
      S_WAIT: begin
        if (gap_cnt == 20'h0) begin
          next_state = S_STROBE;
          next_strobe = dir_down ? strobe_now - 4'h1 : strobe_now + 4'h1;
        end else begin
          next_gap_cnt = gap_cnt - 20'h1;
        end
      end
      S_ON: begin
        if (power_down_req) begin
          next_state = S_STROBE;
          next_dir_down = 1'b1;
          next_strobe = `LAST_STROBE;
          next_busy = 1'b1;
        end
      end
      default: begin
        next_state = S_OFF;
        next_busy = 1'b0;
      end
    endcase
  end

  // Sequencer flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= S_OFF;
      dir_down <= 1'b0;
      strobe_now <= 4'h0;
      gap_cnt <= 20'h0;
      rails <= 8'h00;
      seq_busy <= 1'b0;
    end else begin
      state <= next_state;
      dir_down <= next_dir_down;
      strobe_now <= next_strobe;
      gap_cnt <= next_gap_cnt;
      rails <= next_rails;
      seq_busy <= next_busy;
    end
  end

  // Rail enables straight from the rails flops
  assign buck_boost_rail = rails[0];
  assign third_buck_rail = rails[1];
  assign low_volt_load_switch = rails[2];
  assign linear_reg_rail = rails[3];
  assign gp_output_one = rails[4];
  assign gp_output_three = rails[5];
  assign backup_core_rail = rails[6];
  assign backup_io_rail = rails[7];

endmodule : rail_strobe_slot_assign
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic unlock = 1'b0;
  logic seal = 1'b0;
  logic factor = 1'b0;
  logic up = 1'b0;
  logic down = 1'b0;
  logic [7:0] rdata;
  logic [7:0] en;
  logic [7:0] powered;
  logic [3:0] strobe;
  logic busy;
  int mismatches = 0;
  int comparisons = 0;
  int n;
  always #25 clk = ~clk;
  // Gap between strobes 9 and 10 long, all others short
  rail_strobe_slot_assign #(.GAP_SHORT(6), .GAP_LONG(10), .DOWN_FACTOR(10)) DUT (
    .clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_en), .reg_rd(rd_en),
    .unlock(unlock), .reg_rdata(rdata), .freshness_seal_flag(seal), .gap_delay_select(9'h100),
    .powerdown_delay_factor(factor), .power_up_req(up), .power_down_req(down),
    .buck_boost_rail(en[7]), .third_buck_rail(en[6]), .low_volt_load_switch(en[5]),
    .linear_reg_rail(en[4]), .gp_output_one(en[3]), .gp_output_three(en[2]),
    .backup_core_rail(en[1]), .backup_io_rail(en[0]), .strobe_now(strobe), .seq_busy(busy));
  rail_load_model loads (.enables(en), .powered(powered));
  // Drive and sample just after the edge to stay clear of races
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic arm);
    unlock = arm;
    tick();
    unlock = 1'b0;
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    tick();
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd_en = 1'b1;
    tick();
    rd_en = 1'b0;
    tick();
    chk8(rdata, exp);
  endtask : rd
  task automatic go(input logic rise);
    up = rise;
    down = ~rise;
    tick();
    up = 1'b0;
    down = 1'b0;
    tick();
  endtask : go
  // Bounded wait for a strobe, n counts the cycles taken
  task automatic wait_s(input logic [3:0] s);
    n = 0;
    while (strobe !== s && n < 3000) begin
      tick();
      n++;
    end
    // A strobe that never comes counts against the run
    if (strobe !== s) begin
      mismatches++;
      $display("Error at %0t: strobe wait limit reached", $time);
    end
  endtask : wait_s
  task automatic done(input logic [7:0] exp);
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      tick();
      n++;
    end
    if (busy !== 1'b0) begin
      mismatches++;
      $display("Error at %0t: busy wait limit reached", $time);
    end
    repeat (6) tick();
    chk8(powered, exp);
  endtask : done
  task automatic t_regs();
    rd(8'h23, 8'h84);
    rd(8'h24, 8'h10);
    rd(8'h25, 8'h88);
    rd(8'h26, 8'h08);
    rd(8'h30, 8'h00);
    wr(8'h25, 8'h34, 1'b0);
    rd(8'h25, 8'h88);
    wr(8'h25, 8'h0b, 1'b1);
    rd(8'h25, 8'h0b);
    wr(8'h24, 8'hff, 1'b1);
    rd(8'h24, 8'h33);
  endtask : t_regs
  // Mixed codes: controlled, uncontrolled, both backup strobes
  task automatic t_up();
    wr(8'h23, 8'ha3, 1'b0);
    wr(8'h24, 8'h21, 1'b1);
    wr(8'h26, 8'h5f, 1'b1);
    go(1'b1);
    wait_s(4'h4);
    tick();
    chk8(powered, 8'h43);
    wait_s(4'h9);
    wait_s(4'ha);
    chk8(8'(n), 8'd10);
    done(8'hc7);
  endtask : t_up
  task automatic t_down();
    factor = 1'b1;
    go(1'b0);
    wait_s(4'h9);
    wait_s(4'h8);
    chk8(8'(n), 8'd60);
    done(8'h00);
  endtask : t_down
  // Seal broken while on: backups must survive power-down
  task automatic t_seal();
    factor = 1'b0;
    go(1'b1);
    done(8'hc7);
    seal = 1'b1;
    go(1'b0);
    done(8'h03);
    chk8({4'h0, strobe}, 8'h00);
    go(1'b1);
    done(8'hc7);
    // Backup codes 0h and 3h: a full power-down leaves both alone
    seal = 1'b0;
    wr(8'h24, 8'h30, 1'b1);
    rd(8'h24, 8'h30);
    go(1'b0);
    done(8'h03);
  endtask : t_seal
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    t_regs();
    t_up();
    t_down();
    t_seal();
    tally_and_finish();
  end
  // Whole run needs about a thousand cycles; this allows twenty thousand
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
